// ===== hdl/sacp_pkg.sv
// package: constants, register map and configuration decode for the serial audio config port
// How it works
// R1: while window enable is high, data is shifted in on each shift clock rise
// R2: the enable line also moves the shifted word into its destination register
// R3: the move happens when the window enable falls from high to low
// R4: the host keeps the sampling clock running during every transfer
// R5: speaker amp enable is high only in configurations needing the speaker amplifier
// R6: power down cuts analog enables but keeps every register unchanged
// R7: earpiece volume is a 3-bit code, eight -3 dB steps, seven is unity
// R8: earpiece volume and summing amp power down when earpiece is not selected
// R9: receive audio routes to earpiece, speaker, auxiliary or transmit loopback
// R10: words are five bits, select bit last, one means configuration, zero volume
// R11: volume words load the lower three data bits into the selected volume register
// R12: with six or more bits, only the last five shifted are used
package sacp_pkg;
   localparam int SACP_WORD_BITS = 5;
   localparam int SACP_VOL_BITS  = 3;
   localparam int SACP_CFG_BITS  = 4;

   // wishbone register byte offsets
   localparam logic [3:0] SACP_ADDR_CFG    = 4'h0;
   localparam logic [3:0] SACP_ADDR_VOL    = 4'h4;
   localparam logic [3:0] SACP_ADDR_STATUS = 4'h8;
   localparam logic [3:0] SACP_ADDR_CTRL   = 4'hc;

   // reset values
   localparam logic [3:0] SACP_CFG_RST  = 4'h1;
   localparam logic [2:0] SACP_VOL_RST  = 3'h0;
   localparam logic [7:0] SACP_CNT_RST  = 8'h00;

   // clock cycles from a seen window close to the commit of the word
   localparam logic [1:0] SACP_SETTLE_LOAD = 2'h3;

   // volume register selectors
   localparam logic [1:0] SACP_VSEL_EAR  = 2'h0;
   localparam logic [1:0] SACP_VSEL_SPK  = 2'h1;
   localparam logic [1:0] SACP_VSEL_RING = 2'h2;

   // analog enable field positions
   localparam int SACP_EN_EAR  = 0;
   localparam int SACP_EN_SPK  = 1;
   localparam int SACP_EN_AUX  = 2;
   localparam int SACP_EN_LOOP = 3;
   localparam int SACP_EN_TX   = 4;
   localparam int SACP_EN_BITS = 5;

   // configuration codes with known behaviour, others have plain defaults
   localparam logic [3:0] SACP_CFG_LOOP  = 4'h0;
   localparam logic [3:0] SACP_CFG_STBY  = 4'h1;
   localparam logic [3:0] SACP_CFG_STDA  = 4'h2;
   localparam logic [3:0] SACP_CFG_RING  = 4'h3;
   localparam logic [3:0] SACP_CFG_OHD   = 4'h4;
   localparam logic [3:0] SACP_CFG_RMON  = 4'h5;
   localparam logic [3:0] SACP_CFG_AUXO  = 4'h6;

   // decoded control: analog enables, volume register selector, speaker amp
   function automatic logic [SACP_EN_BITS+2:0] sacp_decode(input logic [3:0] cfg);
      logic [SACP_EN_BITS-1:0] en;
      logic [1:0]              vs;
      logic                    amp;
      en  = '0;
      vs  = SACP_VSEL_RING;
      amp = 1'b0;
      unique case (cfg)
         SACP_CFG_LOOP: begin
            en = 5'h18;
         end
         SACP_CFG_STBY: begin
            en = 5'h10;
         end
         SACP_CFG_STDA: begin
            en = 5'h11;
            vs = SACP_VSEL_EAR;
         end
         SACP_CFG_RING: begin
            en  = 5'h02;
            amp = 1'b1;
         end
         SACP_CFG_OHD: begin
            en  = 5'h12;
            vs  = SACP_VSEL_SPK;
            amp = 1'b1;
         end
         SACP_CFG_RMON: begin
            en  = 5'h13;
            vs  = SACP_VSEL_SPK;
            amp = 1'b1;
         end
         SACP_CFG_AUXO: begin
            en = 5'h14;
         end
         default: begin
            en = 5'h11;
            vs = SACP_VSEL_EAR;
         end
      endcase
      return {amp, vs, en};
   endfunction
endpackage

// ===== hdl/sacp_sync.sv
// two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sacp_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s1_nxt;
   logic [W-1:0] s2_r;
   logic [W-1:0] s2_nxt;

   always_comb begin
      s1_nxt = d_i;
      s2_nxt = s1_r;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
      end
   end

   assign q_o = s2_r;
endmodule
`default_nettype wire

// ===== hdl/sacp_shift.sv
// serial input shifter on the shift clock domain, outputs the word and a saturating bit count
`timescale 1ns/1ps
`default_nettype none
module sacp_shift (
   input  wire logic       serial_shift_clock_i,
   input  wire logic       rst_link_i,
   input  wire logic       shift_window_enable_i,
   input  wire logic       serial_data_i,
   output logic      [4:0] word_o,
   output logic      [7:0] count_o
);
   logic [4:0] sh_r;
   logic [4:0] sh_nxt;
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;

   always_comb begin
      sh_nxt  = sh_r;
      cnt_nxt = cnt_r;
      if (shift_window_enable_i) begin
         sh_nxt  = {sh_r[3:0], serial_data_i}; // R1 R12
         cnt_nxt = (cnt_r == 8'hff) ? cnt_r : cnt_r + 8'h01;
      end
   end

   always_ff @(posedge serial_shift_clock_i) begin
      if (rst_link_i) begin
         sh_r  <= '0;
         cnt_r <= '0;
      end else begin
         sh_r  <= sh_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign word_o  = sh_r;
   assign count_o = cnt_r;
endmodule
`default_nettype wire

// ===== hdl/sacp_top.sv
// serial audio configuration port with wishbone register view
`timescale 1ns/1ps
`default_nettype none
module sacp_top (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        serial_shift_clock_i,
   input  wire logic        rst_link_i,
   input  wire logic        shift_window_enable_i,
   input  wire logic        serial_data_i,
   input  wire logic        sampling_clock_in_i,
   input  wire logic        power_down_in_n_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             speaker_amp_enable_out_o,
   output logic      [4:0]  analog_enable_o,
   output logic      [2:0]  earpiece_vol_o,
   output logic      [2:0]  speaker_vol_o
);
   logic [4:0] link_word;
   logic [7:0] link_cnt;

   sacp_shift u_shift (
      .serial_shift_clock_i  (serial_shift_clock_i),
      .rst_link_i            (rst_link_i),
      .shift_window_enable_i (shift_window_enable_i),
      .serial_data_i         (serial_data_i),
      .word_o                (link_word),
      .count_o               (link_cnt)
   );

   // the window enable, sampling clock and power down are pins: synchronise
   logic [2:0] pins_s;
   sacp_sync #(.W(3)) u_sync_pins (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   ({shift_window_enable_i, sampling_clock_in_i, power_down_in_n_i}),
      .q_o   (pins_s)
   );
   logic win_s;
   logic sci_s;
   logic pdn_n_s;
   assign win_s   = pins_s[2];
   assign sci_s   = pins_s[1];
   assign pdn_n_s = pins_s[0];

   // word and count are stable while the window is low; sampled after the fall
   logic [4:0] word_s;
   logic [7:0] cnt_s;
   sacp_sync #(.W(13)) u_sync_word (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   ({link_word, link_cnt}),
      .q_o   ({word_s, cnt_s})
   );

   logic [3:0] cfg_r;
   logic [3:0] cfg_nxt;
   logic [2:0] vol_ear_r;
   logic [2:0] vol_ear_nxt;
   logic [2:0] vol_spk_r;
   logic [2:0] vol_spk_nxt;
   logic [2:0] vol_ring_r;
   logic [2:0] vol_ring_nxt;
   logic       win_d_r;
   logic       win_d_nxt;
   logic [1:0] settle_r;
   logic [1:0] settle_nxt;
   logic [7:0] last_cnt_r;
   logic [7:0] last_cnt_nxt;
   logic       sci_d_r;
   logic       sci_d_nxt;
   logic       sci_seen_r;
   logic       sci_seen_nxt;
   logic       no_sci_r;
   logic       no_sci_nxt;
   logic [7:0] words_r;
   logic [7:0] words_nxt;
   logic [31:0] dat_r;
   logic [31:0] dat_nxt;
   logic        ack_r;
   logic        ack_nxt;
   logic        amp_r;
   logic        amp_nxt;
   logic [4:0]  en_r;
   logic [4:0]  en_nxt;
   logic [2:0]  spk_out_r;
   logic [2:0]  spk_out_nxt;
   logic [7:0]  dec;
   logic [7:0]  dec_new;
   logic [1:0]  vsel;

   always_comb begin
      dec  = sacp_pkg::sacp_decode(cfg_r);
      vsel = dec[6:5];
   end

   // window close detection and word commit
   always_comb begin
      cfg_nxt      = cfg_r;
      vol_ear_nxt  = vol_ear_r;
      vol_spk_nxt  = vol_spk_r;
      vol_ring_nxt = vol_ring_r;
      win_d_nxt    = win_s;
      settle_nxt   = settle_r;
      last_cnt_nxt = last_cnt_r;
      sci_d_nxt    = sci_s;
      sci_seen_nxt = sci_seen_r;
      no_sci_nxt   = no_sci_r;
      words_nxt    = words_r;
      // a toggle seen in the opening cycle still counts for the new window
      if (win_s && sci_s != sci_d_r) begin
         sci_seen_nxt = 1'b1;
      end else if (win_s && !win_d_r) begin
         sci_seen_nxt = 1'b0;
      end
      if (win_d_r && !win_s) begin
         settle_nxt = sacp_pkg::SACP_SETTLE_LOAD; // R3
         no_sci_nxt = !sci_seen_r; // R4
      end else if (settle_r != 2'h0) begin
         settle_nxt = settle_r - 2'h1;
      end
      if (settle_r == 2'h1 && cnt_s >= 8'(sacp_pkg::SACP_WORD_BITS)) begin
         last_cnt_nxt = cnt_s;
         words_nxt    = words_r + 8'h01;
         if (word_s[0]) begin
            cfg_nxt = word_s[4:1]; // R2 R10 R12
         end else begin
            // first data bit shifted is ignored, so four clocks suffice once primed
            unique case (vsel) // R11 R7
               sacp_pkg::SACP_VSEL_EAR:  vol_ear_nxt  = word_s[3:1];
               sacp_pkg::SACP_VSEL_SPK:  vol_spk_nxt  = word_s[3:1];
               default:                  vol_ring_nxt = word_s[3:1];
            endcase
         end
      end
      // wishbone writes
      if (wb_cyc_i && wb_stb_i && wb_we_i && !ack_r && wb_sel_i[0]) begin
         if (wb_adr_i == sacp_pkg::SACP_ADDR_CFG) begin
            cfg_nxt = wb_dat_i[3:0];
         end
      end
   end

   // analog enables from config, cut by power down
   always_comb begin
      dec_new = sacp_pkg::sacp_decode(cfg_r);
      amp_nxt = dec_new[7]; // R5
      en_nxt  = pdn_n_s ? dec_new[4:0] : 5'h00; // R6 R8 R9
      // speaker volume output follows the speaker register when the config selects it, else the ring register
      spk_out_nxt = (dec_new[6:5] == sacp_pkg::SACP_VSEL_SPK) ? vol_spk_r : vol_ring_r; // R11
   end

   // wishbone read path
   always_comb begin
      ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
      dat_nxt = 32'h0000_0000;
      unique case (wb_adr_i)
         sacp_pkg::SACP_ADDR_CFG:    dat_nxt = {28'h0, cfg_r};
         sacp_pkg::SACP_ADDR_VOL:    dat_nxt = {23'h0, vol_ring_r, vol_spk_r, vol_ear_r};
         sacp_pkg::SACP_ADDR_STATUS: dat_nxt = {last_cnt_r, words_r, 13'h0, no_sci_r,
                                                pdn_n_s, win_s};
         default:                    dat_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_r      <= sacp_pkg::SACP_CFG_RST;
         vol_ear_r  <= sacp_pkg::SACP_VOL_RST;
         vol_spk_r  <= sacp_pkg::SACP_VOL_RST;
         vol_ring_r <= sacp_pkg::SACP_VOL_RST;
         win_d_r    <= 1'b0;
         settle_r   <= 2'h0;
         last_cnt_r <= sacp_pkg::SACP_CNT_RST;
         sci_d_r    <= 1'b0;
         sci_seen_r <= 1'b0;
         no_sci_r   <= 1'b0;
         words_r    <= sacp_pkg::SACP_CNT_RST;
         dat_r      <= 32'h0000_0000;
         ack_r      <= 1'b0;
         amp_r      <= 1'b0;
         en_r       <= 5'h00;
         spk_out_r  <= sacp_pkg::SACP_VOL_RST;
      end else begin
         cfg_r      <= cfg_nxt;
         vol_ear_r  <= vol_ear_nxt;
         vol_spk_r  <= vol_spk_nxt;
         vol_ring_r <= vol_ring_nxt;
         win_d_r    <= win_d_nxt;
         settle_r   <= settle_nxt;
         last_cnt_r <= last_cnt_nxt;
         sci_d_r    <= sci_d_nxt;
         sci_seen_r <= sci_seen_nxt;
         no_sci_r   <= no_sci_nxt;
         words_r    <= words_nxt;
         dat_r      <= dat_nxt;
         ack_r      <= ack_nxt;
         amp_r      <= amp_nxt;
         en_r       <= en_nxt;
         spk_out_r  <= spk_out_nxt;
      end
   end

   assign wb_dat_o                 = dat_r;
   assign wb_ack_o                 = ack_r;
   assign speaker_amp_enable_out_o = amp_r;
   assign analog_enable_o          = en_r;
   assign earpiece_vol_o           = vol_ear_r;
   assign speaker_vol_o            = spk_out_r;

   // power down keeps register contents
   a_pdn_keeps_cfg: assert property (@(posedge clk_i) disable iff (rst_i) // R6
      (!pdn_n_s && settle_r == 2'h0 && !(wb_cyc_i && wb_stb_i && wb_we_i))
      |=> cfg_r == $past(cfg_r))
      else $error("config changed without a write");
   a_pdn_cuts_analog: assert property (@(posedge clk_i) disable iff (rst_i) // R6
      !pdn_n_s |=> en_r == 5'h00)
      else $error("analog enabled during power down");
   a_ear_off_unsel: assert property (@(posedge clk_i) disable iff (rst_i) // R8
      vsel != sacp_pkg::SACP_VSEL_EAR && !dec[0] |=> !en_r[sacp_pkg::SACP_EN_EAR])
      else $error("earpiece powered while not selected");
   a_amp_follows_cfg: assert property (@(posedge clk_i) disable iff (rst_i) // R5
      1'b1 |=> amp_r == $past(dec[7]))
      else $error("speaker amp enable disagrees with config");
   a_commit_after_fall: assert property (@(posedge clk_i) disable iff (rst_i) // R3
      $fell(win_s) |-> ##3 (settle_r == 2'h1))
      else $error("commit not scheduled after window close");
   a_cfg_load_word: assert property (@(posedge clk_i) disable iff (rst_i) // R10
      (settle_r == 2'h1 && cnt_s >= 8'h05 && word_s[0] && !(wb_cyc_i && wb_stb_i && wb_we_i))
      |=> cfg_r == $past(word_s[4:1]))
      else $error("config word not loaded");
   a_vol_load_word: assert property (@(posedge clk_i) disable iff (rst_i) // R11
      (settle_r == 2'h1 && cnt_s >= 8'h05 && !word_s[0] && vsel == sacp_pkg::SACP_VSEL_EAR)
      |=> vol_ear_r == $past(word_s[3:1]))
      else $error("earpiece volume not loaded");
   a_spk_vol_load: assert property (@(posedge clk_i) disable iff (rst_i) // R11
      (settle_r == 2'h1 && cnt_s >= 8'h05 && !word_s[0] && vsel == sacp_pkg::SACP_VSEL_SPK)
      |=> vol_spk_r == $past(word_s[3:1]))
      else $error("speaker volume not loaded");
   a_ring_vol_load: assert property (@(posedge clk_i) disable iff (rst_i) // R11
      (settle_r == 2'h1 && cnt_s >= 8'h05 && !word_s[0] && vsel == sacp_pkg::SACP_VSEL_RING)
      |=> vol_ring_r == $past(word_s[3:1]))
      else $error("ring volume not loaded");
   a_spk_vol_out: assert property (@(posedge clk_i) disable iff (rst_i) // R11
      (vsel == sacp_pkg::SACP_VSEL_SPK) |=> speaker_vol_o == $past(vol_spk_r))
      else $error("speaker volume output not from speaker register");
   a_no_commit_open: assert property (@(posedge clk_i) disable iff (rst_i) // R3
      (win_s && settle_r == 2'h0 && !(wb_cyc_i && wb_stb_i && wb_we_i))
      |=> cfg_r == $past(cfg_r) && vol_ear_r == $past(vol_ear_r))
      else $error("register changed while window open");
   a_pdn_keeps_vol: assert property (@(posedge clk_i) disable iff (rst_i) // R6
      (!pdn_n_s && settle_r == 2'h0)
      |=> vol_ear_r == $past(vol_ear_r) && vol_spk_r == $past(vol_spk_r))
      else $error("volume changed during power down");
   a_loop_routes_tx: assert property (@(posedge clk_i) disable iff (rst_i) // R9
      (cfg_r == sacp_pkg::SACP_CFG_LOOP && pdn_n_s)
      |=> en_r[sacp_pkg::SACP_EN_LOOP] && !en_r[sacp_pkg::SACP_EN_EAR])
      else $error("loopback routing wrong");
   a_cfg_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && wb_we_i && !ack_r && wb_sel_i[0]
       && wb_adr_i == sacp_pkg::SACP_ADDR_CFG) |=> cfg_r == $past(wb_dat_i[3:0]))
      else $error("config write lost");
   a_ack_answers_req: assert property (@(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("bus request not acknowledged");
   a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");
endmodule
`default_nettype wire

// ===== sim/sacp_host.sv
// host model driving the three-wire serial port and the sampling clock
`timescale 1ns/1ps
`default_nettype none
module sacp_host (
   output logic sclk_o,
   output logic rst_link_o,
   output logic win_o,
   output logic sdat_o,
   output logic sci_o
);
   initial begin
      sclk_o = 1'b0;
      rst_link_o = 1'b1;
      win_o = 1'b0;
      sdat_o = 1'b0;
   end
   // sampling clock left running for every transfer
   initial begin
      sci_o = 1'b0;
      forever #20 sci_o = ~sci_o;
   end
   task automatic pulse;
      #3 sclk_o = 1'b1;
      #3 sclk_o = 1'b0;
   endtask
   task automatic link_reset;
      repeat (3) pulse();
      rst_link_o = 1'b0;
   endtask
   task automatic shift(input logic b);
      sdat_o = b;
      pulse();
   endtask
   task automatic open_win;
      win_o = 1'b1;
      #3;
   endtask
   // data bits first, most significant first, select bit last
   task automatic word(input logic [3:0] d, input logic cv);
      for (int i = 3; i >= 0; i--) shift(d[i]);
      shift(cv);
   endtask
   // released data line shows the inverse of its last level
   task automatic close_win;
      #3 win_o = 1'b0;
      sdat_o = ~sdat_o;
   endtask
endmodule
`default_nettype wire

// ===== sim/sacp_tb.sv
// self-checking bench for the serial audio config port
`timescale 1ns/1ps
`default_nettype none
module sacp_tb;
   localparam logic [4:0] EN_T [8] = '{5'h18, 5'h10, 5'h11, 5'h02, 5'h12, 5'h13, 5'h14, 5'h11};
   localparam logic [7:0] AMP_T = 8'h38;
   logic        clk_i;
   logic        rst_i;
   logic        sclk, rst_link, win, sdat, sampling_clock_in, pdn_n;
   logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, amp;
   logic [3:0]  wb_adr_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [4:0]  aen;
   logic [2:0]  ear_v, spk_v;
   int          miscompares, n_compared, cyc;
   sacp_host sacp_host_inst (.sclk_o(sclk), .rst_link_o(rst_link), .win_o(win),
      .sdat_o(sdat), .sci_o(sampling_clock_in));
   sacp_top sacp_top_inst (.clk_i(clk_i), .rst_i(rst_i), .serial_shift_clock_i(sclk),
      .rst_link_i(rst_link), .shift_window_enable_i(win), .serial_data_i(sdat),
      .sampling_clock_in_i(sampling_clock_in), .power_down_in_n_i(pdn_n), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .speaker_amp_enable_out_o(amp), .analog_enable_o(aen), .earpiece_vol_o(ear_v),
      .speaker_vol_o(spk_v));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic tally_and_finish;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 30000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic sendw(input logic [3:0] d, input logic cv);
      sacp_host_inst.open_win();
      sacp_host_inst.word(d, cv);
      sacp_host_inst.close_win();
      repeat (10) @(posedge clk_i);
   endtask
   initial begin
      rst_i = 1'b1;
      pdn_n = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 4'h0;
      wb_dat_i = 32'h0;
      sacp_host_inst.link_reset();
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      wb(1'b0, 4'h0, 32'h0);
      chk(rd, 32'h1);
      wb(1'b0, 4'h4, 32'h0);
      chk(rd, 32'h0);
      chk(aen, 5'h10);
      $display("test reset done");
      for (int c = 0; c < 8; c++) begin
         sacp_host_inst.open_win();
         sacp_host_inst.word(c[3:0], 1'b1);
         repeat (10) @(posedge clk_i);
         chk(aen, (c == 0) ? EN_T[1] : EN_T[c - 1]);
         sacp_host_inst.close_win();
         repeat (10) @(posedge clk_i);
         chk(aen, EN_T[c]);
         chk(amp, AMP_T[c]);
         wb(1'b0, 4'h0, 32'h0);
         chk(rd, c);
      end
      $display("test config done");
      sacp_host_inst.open_win();
      sacp_host_inst.shift(1'b1);
      sacp_host_inst.shift(1'b1);
      sacp_host_inst.word(4'h4, 1'b1);
      sacp_host_inst.close_win();
      repeat (10) @(posedge clk_i);
      chk(aen, 5'h12);
      chk(amp, 1'b1);
      $display("test long window done");
      sendw(4'b1011, 1'b0);
      chk(spk_v, 3'h3);
      sendw(4'h2, 1'b1);
      sendw(4'b1101, 1'b0);
      chk(ear_v, 3'h5);
      wb(1'b0, 4'h4, 32'h0);
      chk(rd, 32'h1d);
      $display("test volume done");
      pdn_n <= 1'b0;
      repeat (10) @(posedge clk_i);
      chk(aen, 5'h00);
      wb(1'b0, 4'h0, 32'h0);
      chk(rd, 32'h2);
      wb(1'b0, 4'h4, 32'h0);
      chk(rd, 32'h1d);
      pdn_n <= 1'b1;
      repeat (10) @(posedge clk_i);
      chk(aen, 5'h11);
      $display("test power down done");
      wb(1'b1, 4'h0, 32'h6);
      repeat (5) @(posedge clk_i);
      chk(aen, 5'h14);
      sendw(4'b0110, 1'b0);
      chk(spk_v, 3'h6);
      wb(1'b1, 4'h4, 32'h0);
      wb(1'b0, 4'h4, 32'h0);
      chk(rd, 32'h19d);
      wb(1'b0, 4'hc, 32'h0);
      chk(rd, 32'h0);
      wb(1'b0, 4'h8, 32'h0);
      chk(rd, 32'h430d_0002);
      $display("test bus done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
